// >>> rtl/apm_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module apm_ctrl #(
  parameter int RES_W = apm_pkg::RES_BITS,
  parameter int DEPTH = apm_pkg::FIFO_DEPTH
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_sample_valid,
  output logic o_sample_ready,
  input wire logic [RES_W-1:0] i_sample_data,
  output logic o_result_out,
  output logic o_result_oe,
  output logic o_hold,
  output logic o_powered,
  output logic o_shutdown,
  output logic o_result_usable
);
  // Pin synchronisers and edge registers
  logic [1:0] cs_sync_q;
  logic [1:0] cs_sync_d;
  logic [1:0] sclk_sync_q;
  logic [1:0] sclk_sync_d;
  logic cs_n_q;
  logic sclk_q;
  // Frame counters
  logic [4:0] fall_cnt_q;
  logic [4:0] fall_cnt_d;
  logic [4:0] rise_cnt_q;
  logic [4:0] rise_cnt_d;
  // Mode and power state
  logic shut_q;
  logic shut_d;
  logic waking_q;
  logic waking_d;
  logic [7:0] pwr_cnt_q;
  logic [7:0] pwr_cnt_d;
  // Result path
  logic [RES_W-1:0] word_q;
  logic [RES_W-1:0] word_d;
  logic [apm_pkg::FRAME_EDGES-1:0] shreg_q;
  logic [apm_pkg::FRAME_EDGES-1:0] shreg_d;
  logic out_q;
  logic out_d;
  logic oe_q;
  logic oe_d;
  logic hold_q;
  logic hold_d;
  logic usable_q;
  logic usable_d;
  apm_pkg::apm_state_t state_q;
  apm_pkg::apm_state_t state_d;
  logic fifo_valid;
  logic [RES_W-1:0] fifo_data;

  // Pin events, seen only after two flip-flops
  assign cs_sync_d = {cs_sync_q[0], i_cs_n};
  assign sclk_sync_d = {sclk_sync_q[0], i_sclk};
  wire cs_n_s = cs_sync_q[1];
  wire sclk_s = sclk_sync_q[1];
  wire cs_fall = cs_n_q && !cs_n_s;
  wire cs_rise = !cs_n_q && cs_n_s;
  wire sclk_fall = sclk_q && !sclk_s && !cs_n_s;
  wire sclk_rise = !sclk_q && sclk_s && !cs_n_s;

  // Frame position
  wire in_idle = (state_q == apm_pkg::APM_IDLE);
  wire in_frame = (state_q == apm_pkg::APM_FRAME);
  wire in_done = (state_q == apm_pkg::APM_DONE);
  wire start_frame = cs_fall && in_idle;
  wire end_frame = cs_rise && in_frame;
  wire early = fall_cnt_q < apm_pkg::SHUT_MIN_EDGE;
  wire before_ten = fall_cnt_q < apm_pkg::NORMAL_MIN_EDGE;
  wire full_word = fall_cnt_q >= apm_pkg::FULL_EDGE;
  wire word_done = in_frame && full_word;
  wire count_fall = sclk_fall && in_frame && !full_word;
  wire count_rise = sclk_rise && in_frame && (rise_cnt_q != apm_pkg::FULL_EDGE);
  wire track_edge = sclk_rise && in_frame && (rise_cnt_q == apm_pkg::TRACK_RISE - 5'h01);
  wire shift_bit = sclk_fall && in_frame;

  assign fall_cnt_d = start_frame ? 5'h00 : count_fall ? fall_cnt_q + 5'h01 : fall_cnt_q;
  assign rise_cnt_d = start_frame ? 5'h00 : count_rise ? rise_cnt_q + 5'h01 : rise_cnt_q;

  // Mode decision at select rise; under two edges counts as noise
  wire wake_abort = waking_q && before_ten;
  wire shut_abort = !early && before_ten;
  wire glitch_keep = early && shut_q;
  // Ten or more edges leave the device in normal mode
  wire shut_next = wake_abort || shut_abort || glitch_keep;
  assign shut_d = start_frame ? 1'b0 : end_frame ? shut_next : shut_q;
  assign waking_d = start_frame ? shut_q : (end_frame || word_done) ? 1'b0 : waking_q;

  // Power-up timer restarts on every exit from shutdown
  wire pwr_done = (pwr_cnt_q == 8'(apm_pkg::PWRUP_CYCLES));
  assign pwr_cnt_d = shut_q ? 8'h00 : pwr_done ? pwr_cnt_q : pwr_cnt_q + 8'h01;

  always_comb begin
    state_d = state_q;
    case (state_q)
      apm_pkg::APM_IDLE: begin
        if (cs_fall) begin
          state_d = apm_pkg::APM_FRAME;
        end
      end
      apm_pkg::APM_FRAME: begin
        if (cs_rise) begin
          state_d = apm_pkg::APM_IDLE;
        end else if (full_word) begin
          state_d = apm_pkg::APM_DONE;
        end
      end
      apm_pkg::APM_DONE: begin
        // Select idled low is ignored until it rises
        if (cs_rise) begin
          state_d = apm_pkg::APM_IDLE;
        end
      end
      default: begin
        state_d = apm_pkg::APM_IDLE;
      end
    endcase
  end

  // Empty queue repeats the last word rather than stalling the host
  wire [RES_W-1:0] load_word = fifo_valid ? fifo_data : word_q;
  wire fifo_pop = start_frame && fifo_valid;
  wire [apm_pkg::FRAME_EDGES-1:0] shreg_shift = shift_bit ? {shreg_q[apm_pkg::FRAME_EDGES-2:0], 1'b0} : shreg_q;
  assign word_d = start_frame ? load_word : word_q;
  assign shreg_d = start_frame ? {{apm_pkg::LEAD_ZEROS{1'b0}}, load_word} : shreg_shift;
  assign out_d = start_frame ? 1'b0 : shift_bit ? shreg_q[apm_pkg::FRAME_EDGES-1] : out_q;
  assign oe_d = start_frame ? 1'b1 : (cs_rise || word_done) ? 1'b0 : oe_q;
  assign hold_d = start_frame ? 1'b1 : (cs_rise || track_edge) ? 1'b0 : hold_q;
  // Frame opening in shutdown or before the timer ends carries a stale word
  assign usable_d = start_frame ? !(shut_q || !pwr_done) : usable_q;

  // Converter results queue here; a full queue stalls the source through o_sample_ready
  apm_fifo #(.WIDTH(RES_W), .DEPTH(DEPTH)) u_fifo (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_in_valid(i_sample_valid),
    .o_in_ready(o_sample_ready),
    .i_in_data(i_sample_data),
    .o_out_valid(fifo_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_data)
  );

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cs_sync_q <= 2'h3;
    end else begin
      cs_sync_q <= cs_sync_d;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sclk_sync_q <= 2'h0;
    end else begin
      sclk_sync_q <= sclk_sync_d;
    end
  end

  // Edge registers reset to the idle pin levels, so reset makes no false edge
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cs_n_q <= 1'b1;
    end else begin
      cs_n_q <= cs_n_s;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk_s;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= apm_pkg::APM_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      fall_cnt_q <= 5'h00;
    end else begin
      fall_cnt_q <= fall_cnt_d;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rise_cnt_q <= 5'h00;
    end else begin
      rise_cnt_q <= rise_cnt_d;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      shut_q <= 1'b0;
    end else begin
      shut_q <= shut_d;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      waking_q <= 1'b0;
    end else begin
      waking_q <= waking_d;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pwr_cnt_q <= 8'h00;
    end else begin
      pwr_cnt_q <= pwr_cnt_d;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      word_q <= '0;
    end else begin
      word_q <= word_d;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      shreg_q <= '0;
    end else begin
      shreg_q <= shreg_d;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      out_q <= 1'b0;
    end else begin
      out_q <= out_d;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= oe_d;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      hold_q <= 1'b0;
    end else begin
      hold_q <= hold_d;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      usable_q <= 1'b0;
    end else begin
      usable_q <= usable_d;
    end
  end

  // Sixteenth edge drives the LSB; float begins the cycle after
  assign o_result_out = out_q;
  assign o_result_oe = oe_q && !in_done;
  assign o_hold = hold_q;
  assign o_powered = pwr_done && !waking_q && !shut_q;
  assign o_shutdown = shut_q;
  assign o_result_usable = usable_q;
endmodule
`default_nettype wire

// >>> rtl/apm_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module apm_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;
  assign o_in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data = mem_q[rd_q];
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      if (pop) rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (push) mem_q[wr_q] <= i_in_data;
  end
endmodule
`default_nettype wire

// >>> rtl/apm_pkg.sv
package apm_pkg;
  localparam int unsigned RES_BITS = 12;
  localparam int unsigned LEAD_ZEROS = 4;
  localparam int unsigned FRAME_EDGES = 16;
  localparam logic [4:0] SHUT_MIN_EDGE = 5'h02;
  localparam logic [4:0] NORMAL_MIN_EDGE = 5'h0a;
  localparam logic [4:0] FULL_EDGE = 5'h10;
  localparam logic [4:0] TRACK_RISE = 5'h0d;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned PWRUP_TIME_NS = 1000;
  localparam int unsigned PWRUP_CYCLES = (PWRUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FIFO_DEPTH = 8;
  typedef enum logic [1:0] {APM_IDLE, APM_FRAME, APM_DONE} apm_state_t;
endpackage

// >>> verification/apm_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module apm_ctrl_chk (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic o_sample_ready,
  input wire logic o_result_out,
  input wire logic o_result_oe,
  input wire logic o_hold,
  input wire logic o_powered,
  input wire logic o_shutdown
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  a_rst_quiet: assert property (disable iff (1'b0) i_rst |-> !o_result_oe && !o_hold)
    else $error("output active in reset");
  a_oe_off: assert property ($rose(i_cs_n) |-> ##[1:6] !o_result_oe)
    else $error("output not floated after select rise");
  a_oe_on: assert property ($fell(i_cs_n) |-> ##[2:6] o_result_oe)
    else $error("output not driven after select fall");
  a_hold_oe: assert property (o_hold |-> o_result_oe)
    else $error("hold outside a driven frame");
  a_lead_zero: assert property ($rose(o_result_oe) |-> !o_result_out)
    else $error("frame does not open with zero");
  a_shut_rise: assert property ($rose(o_shutdown) |-> i_cs_n && $past(i_cs_n, 2))
    else $error("shutdown entered while selected");
  a_shut_exit: assert property ($fell(o_shutdown) |-> !o_powered)
    else $error("powered at once on wake");
  a_ready_rst: assert property ($fell(i_rst) |-> o_sample_ready)
    else $error("buffer not empty after reset");
  c_shut: cover property ($rose(o_shutdown));
  c_wake: cover property ($fell(o_shutdown));
  c_full: cover property (!o_sample_ready);
endmodule
bind apm_ctrl apm_ctrl_chk u_chk (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_cs_n(i_cs_n), .o_sample_ready(o_sample_ready),
  .o_result_out(o_result_out), .o_result_oe(o_result_oe), .o_hold(o_hold),
  .o_powered(o_powered), .o_shutdown(o_shutdown));
`default_nettype wire

// >>> verification/apm_host.sv
`timescale 1ns/1ps
`default_nettype none
module apm_host (
  input wire logic i_core_clk,
  input wire logic i_result_out,
  output logic o_cs_n,
  output logic o_sclk
);
  logic [15:0] rx_q;
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    rx_q = 16'h0000;
  end
  // Serial clock stands low between frames; first edge is a rise so lead zeros are valid
  task automatic frame(input int n);
    o_cs_n <= 1'b0;
    repeat (4) @(posedge i_core_clk);
    for (int i = 0; i < n; i++) begin
      o_sclk <= 1'b1;
      repeat (4) @(posedge i_core_clk);
      o_sclk <= 1'b0;
      repeat (6) @(posedge i_core_clk);
      rx_q <= {rx_q[14:0], i_result_out};
    end
    o_cs_n <= 1'b1; // Always raised before the next frame
    repeat (12) @(posedge i_core_clk); // Quiet gap
  endtask
endmodule
`default_nettype wire

// >>> verification/tb_adc_power_mode_serial_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_adc_power_mode_serial_control;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_sample_valid = 1'b0;
  logic [11:0] i_sample_data = 12'h000;
  logic cs_n, sclk, rdy, sout, oe, hold, pwr, shut, usable;
  int mismatches = 0;
  int check_count = 0;
  always #50 i_core_clk = ~i_core_clk;
  apm_host host (.i_core_clk(i_core_clk), .i_result_out(sout), .o_cs_n(cs_n), .o_sclk(sclk));
  apm_ctrl dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_sclk(sclk),
    .i_sample_valid(i_sample_valid), .o_sample_ready(rdy), .i_sample_data(i_sample_data),
    .o_result_out(sout), .o_result_oe(oe), .o_hold(hold), .o_powered(pwr),
    .o_shutdown(shut), .o_result_usable(usable));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done();
    if (mismatches == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic t_fill();
    for (int i = 0; i < 8; i++) begin
      i_sample_valid <= 1'b1;
      i_sample_data <= {8'h9c, 4'(i)};
      @(posedge i_core_clk);
    end
    i_sample_valid <= 1'b0;
    @(posedge i_core_clk);
    chk("ready_full", 16'h0000, {15'h0, rdy});
  endtask
  task automatic t_frames();
    host.frame(16); // First frame after reset reads the oldest queued word
    chk("word0", 16'h09c0, host.rx_q);
    host.frame(16);
    chk("word1", 16'h09c1, host.rx_q);
    chk("usable1", 16'h0001, {15'h0, usable});
    chk("hold_end", 16'h0000, {15'h0, hold});
    chk("oe_end", 16'h0000, {15'h0, oe});
    chk("shut_full", 16'h0000, {15'h0, shut});
  endtask
  task automatic t_glitch();
    host.frame(1);
    chk("shut_glitch", 16'h0000, {15'h0, shut});
  endtask
  task automatic t_shut();
    host.frame(5);
    chk("shut_enter", 16'h0001, {15'h0, shut});
    chk("oe_shut", 16'h0000, {15'h0, oe});
  endtask
  task automatic t_wake();
    host.frame(1);
    chk("shut_back", 16'h0001, {15'h0, shut});
    host.frame(16); // Result discarded after wake
    chk("shut_wake", 16'h0000, {15'h0, shut});
    chk("powered", 16'h0001, {15'h0, pwr});
    chk("usable_wake", 16'h0000, {15'h0, usable});
    host.frame(16);
    chk("word6", 16'h09c6, host.rx_q);
    chk("usable_second", 16'h0001, {15'h0, usable});
  endtask
  task automatic t_abort();
    host.frame(12);
    chk("trunc", 16'h009c, {4'h0, host.rx_q[11:0]});
    chk("shut_abort", 16'h0000, {15'h0, shut});
    chk("oe_abort", 16'h0000, {15'h0, oe});
    chk("hold_abort", 16'h0000, {15'h0, hold});
    chk("ready_empty", 16'h0001, {15'h0, rdy});
  endtask
  initial begin
    repeat (20) @(posedge i_core_clk);
    i_rst <= 1'b0;
    @(posedge i_core_clk);
    t_fill();
    t_frames();
    t_glitch();
    t_shut();
    t_wake();
    t_abort();
    test_done();
  end
  // About 1000 cycles expected
  initial begin
    repeat (20000) @(posedge i_core_clk);
    mismatches++;
    test_done();
  end
endmodule
`default_nettype wire
